// ==== include/ldg_params.svh ====
// offsets, field positions, reset values and address limits for the decoder
`ifndef LDG_PARAMS_SVH
`define LDG_PARAMS_SVH

// configuration register indexes
`define LDG_IDX_CFG_HIGH 8'h12
`define LDG_IDX_CFG_LOW 8'h13
`define LDG_IDX_FDC 8'h20
`define LDG_IDX_LPT 8'h23
`define LDG_IDX_UART1 8'h24
`define LDG_IDX_UART2 8'h25
`define LDG_IDX_IR 8'h2b
`define LDG_IDX_RT 8'h30

// base register reset value (base invalid until programmed)
`define LDG_BASE_RST 8'h00

// configuration port power-up locations
`define LDG_CFG_PORT_STRAP_LO 16'h002e
`define LDG_CFG_PORT_STRAP_HI 16'h004e

// lowest legal base, highest legal bases
`define LDG_BASE_MIN 16'h0100
`define LDG_FDC_MAX 16'h03f8
`define LDG_LPT_MAX 16'h03fc
`define LDG_UART_MAX 16'h03f8
`define LDG_IR_MAX 16'h07f8
`define LDG_RT_MAX 16'h0ff0
`define LDG_CFG_MAX 16'h07fe

// register offsets within device windows
`define LDG_FDC_HOLE_OFF 16'h0006
`define LDG_FDC_SPAN 16'h0008
`define LDG_LPT_STD_SPAN 16'h0003
`define LDG_LPT_EPP_SPAN 16'h0008
`define LDG_LPT_FIFO_OFF 16'h0400
`define LDG_LPT_ECR_OFF 16'h0402
`define LDG_UART_SPAN 16'h0008
`define LDG_IR_SPAN 16'h0008
`define LDG_RT_SPAN 16'h0010

// extended control modes that force the printer interrupt on
`define LDG_ECR_FIFO 3'b010
`define LDG_ECR_ECP 3'b011
`define LDG_ECR_TEST 3'b110

`endif

// ==== include/ldg_pkg.sv ====
// types shared by the logical device decoder
package ldg_pkg;

	typedef logic [15:0] ldg_addr_t;

	// logical devices in claim-vector order
	typedef enum {
		LDG_FDC,
		LDG_LPT,
		LDG_UART1,
		LDG_UART2,
		LDG_IR,
		LDG_RT,
		LDG_CFG
	} ldg_dev_e;

endpackage : ldg_pkg

// ==== design/ldg_gate.sv ====
// per-device interrupt and dma request gate with registered outputs
`timescale 1ns/1ps
module ldg_gate
	import ldg_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	input wire logic irq_req,
	input wire logic dma_req,
	input wire logic irq_en,
	input wire logic dma_en,
	output logic irq_out_r,
	output logic dma_out_r
);

	logic irq_out_nxt;
	logic dma_out_nxt;

	// pass requests only while enabled
	always_comb begin
		irq_out_nxt = irq_req & irq_en;
		dma_out_nxt = dma_req & dma_en;
	end

	// register the gated requests
	always_ff @(posedge clock) begin
		if (rst) begin
			irq_out_r <= 1'b0;
			dma_out_r <= 1'b0;
		end else if (ce) begin
			irq_out_r <= irq_out_nxt;
			dma_out_r <= dma_out_nxt;
		end
	end

endmodule : ldg_gate

// ==== design/ldg_decode.sv ====
// host i/o decoder, configuration port and irq/dma gating
// What this block does
// - floppy block at 8-aligned base, offset six unclaimed
// - 4-aligned printer base: only data, status, control
// - 8-aligned printer base adds offsets three to seven
// - printer fifo at base+400h, ecr at +402h
// - each uart is eight registers, 8-aligned base
// - infrared block is eight offsets up to 7f8h
// - runtime block sixteen offsets, 16-aligned base
// - configuration port relocatable, two-byte aligned
// - index at port, data at port plus one
// - power-up port from strap, moves on relocation write
// - inactive or invalid device gets no irq/dma
// - floppy gated by output control dma bit
// - floppy gated off while powered down
// - uart interrupt gated by aux output two
// - second uart dma gated by infrared enable
// - standard/enhanced printer irq gated by enable bit
// - printer dma gated only by ecr dma bit
// - printer irq forced on in modes 010,011,110
`timescale 1ns/1ps
`include "ldg_params.svh"
module ldg_decode
	import ldg_pkg::*;
#(
	parameter int NUM_GATED = 5
)
(
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	input wire logic port_location_strap,
	input wire logic [15:0] io_addr,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [7:0] io_wdata,
	input wire logic [5:0] dev_active,
	input wire logic floppy_dma_irq_gate,
	input wire logic floppy_powerdown,
	input wire logic [1:0] aux_output_two,
	input wire logic uart2_dma_enable,
	input wire logic printer_irq_gate,
	input wire logic printer_dma_gate,
	input wire logic printer_ecr_active,
	input wire logic [2:0] printer_ecr_mode,
	input wire logic [4:0] irq_req,
	input wire logic [4:0] dma_req,
	output logic [4:0] irq_out_r,
	output logic [4:0] dma_out_r,
	output logic [6:0] claim_r,
	output logic [15:0] claim_offset_r,
	output logic [7:0] cfg_rdata_r,
	output logic cfg_rvalid_r,
	output logic [15:0] cfg_port_r
);

	// distance of an address above a base, all 16 bits compared
	function automatic ldg_addr_t addr_off(input ldg_addr_t a,
		input ldg_addr_t b);
		addr_off = a - b;
	endfunction : addr_off

	// true when address is at or above base and offset below span
	function automatic logic in_span(input ldg_addr_t a, input ldg_addr_t b,
		input ldg_addr_t span);
		in_span = (a >= b) && (addr_off(a, b) < span);
	endfunction : in_span

	// configuration register state
	logic [7:0] cfg_index_r, cfg_index_nxt;
	logic [15:0] cfg_port_nxt;
	logic [7:0] fdc_base_r, fdc_base_nxt;
	logic [7:0] lpt_base_r, lpt_base_nxt;
	logic [7:0] uart1_base_r, uart1_base_nxt;
	logic [7:0] uart2_base_r, uart2_base_nxt;
	logic [7:0] ir_base_r, ir_base_nxt;
	logic [7:0] rt_base_r, rt_base_nxt;
	logic [7:0] cfg_rdata_nxt;
	logic cfg_rvalid_nxt;
	logic [6:0] claim_nxt;
	logic [15:0] claim_offset_nxt;

	// expanded bases and validity
	ldg_addr_t fdc_base, lpt_base, uart1_base, uart2_base, ir_base, rt_base;
	logic fdc_ok, lpt_ok, lpt_wide, uart1_ok, uart2_ok, ir_ok, rt_ok;
	logic cfg_idx_hit, cfg_dat_hit;

	// bases are register value times four (infrared times eight, runtime times sixteen)
	always_comb begin
		fdc_base = {6'h00, fdc_base_r, 2'b00};
		lpt_base = {6'h00, lpt_base_r, 2'b00};
		uart1_base = {6'h00, uart1_base_r, 2'b00};
		uart2_base = {6'h00, uart2_base_r, 2'b00};
		ir_base = {5'h00, ir_base_r, 3'b000};
		rt_base = {4'h0, rt_base_r, 4'h0};
		fdc_ok = fdc_base >= `LDG_BASE_MIN && fdc_base <= `LDG_FDC_MAX
			&& fdc_base[2] == 1'b0;
		lpt_ok = lpt_base >= `LDG_BASE_MIN && lpt_base <= `LDG_LPT_MAX;
		lpt_wide = lpt_base[2] == 1'b0;
		uart1_ok = uart1_base >= `LDG_BASE_MIN && uart1_base <= `LDG_UART_MAX
			&& uart1_base[2] == 1'b0;
		uart2_ok = uart2_base >= `LDG_BASE_MIN && uart2_base <= `LDG_UART_MAX
			&& uart2_base[2] == 1'b0;
		ir_ok = ir_base >= `LDG_BASE_MIN && ir_base <= `LDG_IR_MAX;
		rt_ok = rt_base >= `LDG_BASE_MIN && rt_base <= `LDG_RT_MAX;
		cfg_idx_hit = io_addr == cfg_port_r;
		cfg_dat_hit = io_addr == cfg_port_r + 16'h0001;
	end

	// address claim for each logical device
	always_comb begin
		claim_nxt = 7'h00;
		claim_offset_nxt = 16'h0000;
		if (io_wr || io_rd) begin
			if (dev_active[LDG_FDC] && fdc_ok
				&& in_span(io_addr, fdc_base, `LDG_FDC_SPAN)
				&& addr_off(io_addr, fdc_base) != `LDG_FDC_HOLE_OFF) begin
				claim_nxt[LDG_FDC] = 1'b1;
				claim_offset_nxt = addr_off(io_addr, fdc_base);
			end
			if (dev_active[LDG_LPT] && lpt_ok) begin
				if (in_span(io_addr, lpt_base, `LDG_LPT_STD_SPAN)
					|| (lpt_wide
					&& in_span(io_addr, lpt_base, `LDG_LPT_EPP_SPAN))
					|| addr_off(io_addr, lpt_base) == `LDG_LPT_FIFO_OFF
					|| addr_off(io_addr, lpt_base) == `LDG_LPT_ECR_OFF) begin
					claim_nxt[LDG_LPT] = 1'b1;
					claim_offset_nxt = addr_off(io_addr, lpt_base);
				end
			end
			if (dev_active[LDG_UART1] && uart1_ok
				&& in_span(io_addr, uart1_base, `LDG_UART_SPAN)) begin
				claim_nxt[LDG_UART1] = 1'b1;
				claim_offset_nxt = addr_off(io_addr, uart1_base);
			end
			if (dev_active[LDG_UART2] && uart2_ok
				&& in_span(io_addr, uart2_base, `LDG_UART_SPAN)) begin
				claim_nxt[LDG_UART2] = 1'b1;
				claim_offset_nxt = addr_off(io_addr, uart2_base);
			end
			if (dev_active[LDG_IR] && ir_ok
				&& in_span(io_addr, ir_base, `LDG_IR_SPAN)) begin
				claim_nxt[LDG_IR] = 1'b1;
				claim_offset_nxt = addr_off(io_addr, ir_base);
			end
			if (dev_active[LDG_RT] && rt_ok
				&& in_span(io_addr, rt_base, `LDG_RT_SPAN)) begin
				claim_nxt[LDG_RT] = 1'b1;
				claim_offset_nxt = addr_off(io_addr, rt_base);
			end
			if (cfg_idx_hit || cfg_dat_hit) begin
				claim_nxt[LDG_CFG] = 1'b1;
				claim_offset_nxt = cfg_dat_hit ? 16'h0001 : 16'h0000;
			end
		end
	end

	// index/data access to the configuration registers
	always_comb begin
		cfg_index_nxt = cfg_index_r;
		cfg_port_nxt = cfg_port_r;
		fdc_base_nxt = fdc_base_r;
		lpt_base_nxt = lpt_base_r;
		uart1_base_nxt = uart1_base_r;
		uart2_base_nxt = uart2_base_r;
		ir_base_nxt = ir_base_r;
		rt_base_nxt = rt_base_r;
		cfg_rdata_nxt = cfg_rdata_r;
		cfg_rvalid_nxt = 1'b0;
		if (io_wr && cfg_idx_hit) begin
			cfg_index_nxt = io_wdata;
		end
		if (io_wr && cfg_dat_hit) begin
			case (cfg_index_r)
				`LDG_IDX_CFG_HIGH: cfg_port_nxt[15:8] = io_wdata;
				`LDG_IDX_CFG_LOW: cfg_port_nxt[7:0] = {io_wdata[7:1], 1'b0};
				`LDG_IDX_FDC: fdc_base_nxt = io_wdata;
				`LDG_IDX_LPT: lpt_base_nxt = io_wdata;
				`LDG_IDX_UART1: uart1_base_nxt = io_wdata;
				`LDG_IDX_UART2: uart2_base_nxt = io_wdata;
				`LDG_IDX_IR: ir_base_nxt = io_wdata;
				`LDG_IDX_RT: rt_base_nxt = io_wdata;
				default: cfg_index_nxt = cfg_index_r;
			endcase
		end
		if (io_rd && (cfg_idx_hit || cfg_dat_hit)) begin
			cfg_rvalid_nxt = 1'b1;
			if (cfg_idx_hit) begin
				cfg_rdata_nxt = cfg_index_r;
			end else begin
				case (cfg_index_r)
					`LDG_IDX_CFG_HIGH: cfg_rdata_nxt = cfg_port_r[15:8];
					`LDG_IDX_CFG_LOW: cfg_rdata_nxt = cfg_port_r[7:0];
					`LDG_IDX_FDC: cfg_rdata_nxt = fdc_base_r;
					`LDG_IDX_LPT: cfg_rdata_nxt = lpt_base_r;
					`LDG_IDX_UART1: cfg_rdata_nxt = uart1_base_r;
					`LDG_IDX_UART2: cfg_rdata_nxt = uart2_base_r;
					`LDG_IDX_IR: cfg_rdata_nxt = ir_base_r;
					`LDG_IDX_RT: cfg_rdata_nxt = rt_base_r;
					default: cfg_rdata_nxt = 8'h00;
				endcase
			end
		end
	end

	// register configuration, claim and read state
	always_ff @(posedge clock) begin
		if (rst) begin
			cfg_port_r <= port_location_strap ? `LDG_CFG_PORT_STRAP_HI
				: `LDG_CFG_PORT_STRAP_LO;
			cfg_index_r <= 8'h00;
			fdc_base_r <= `LDG_BASE_RST;
			lpt_base_r <= `LDG_BASE_RST;
			uart1_base_r <= `LDG_BASE_RST;
			uart2_base_r <= `LDG_BASE_RST;
			ir_base_r <= `LDG_BASE_RST;
			rt_base_r <= `LDG_BASE_RST;
			cfg_rdata_r <= 8'h00;
			cfg_rvalid_r <= 1'b0;
			claim_r <= 7'h00;
			claim_offset_r <= 16'h0000;
		end else if (ce) begin
			cfg_port_r <= cfg_port_nxt;
			cfg_index_r <= cfg_index_nxt;
			fdc_base_r <= fdc_base_nxt;
			lpt_base_r <= lpt_base_nxt;
			uart1_base_r <= uart1_base_nxt;
			uart2_base_r <= uart2_base_nxt;
			ir_base_r <= ir_base_nxt;
			rt_base_r <= rt_base_nxt;
			cfg_rdata_r <= cfg_rdata_nxt;
			cfg_rvalid_r <= cfg_rvalid_nxt;
			claim_r <= claim_nxt;
			claim_offset_r <= claim_offset_nxt;
		end
	end

	// per-device enables from configuration and device-local bits
	logic [4:0] dev_ok;
	logic [4:0] irq_en;
	logic [4:0] dma_en;
	logic lpt_irq_forced;

	always_comb begin
		dev_ok[LDG_FDC] = dev_active[LDG_FDC] & fdc_ok;
		dev_ok[LDG_LPT] = dev_active[LDG_LPT] & lpt_ok;
		dev_ok[LDG_UART1] = dev_active[LDG_UART1] & uart1_ok;
		dev_ok[LDG_UART2] = dev_active[LDG_UART2] & uart2_ok;
		dev_ok[LDG_IR] = dev_active[LDG_IR] & ir_ok;
		lpt_irq_forced = printer_ecr_active
			&& (printer_ecr_mode == `LDG_ECR_FIFO
			|| printer_ecr_mode == `LDG_ECR_ECP
			|| printer_ecr_mode == `LDG_ECR_TEST);
		irq_en[LDG_FDC] = dev_ok[LDG_FDC] & floppy_dma_irq_gate
			& ~floppy_powerdown;
		dma_en[LDG_FDC] = irq_en[LDG_FDC];
		irq_en[LDG_LPT] = dev_ok[LDG_LPT]
			& (lpt_irq_forced | printer_irq_gate);
		dma_en[LDG_LPT] = dev_ok[LDG_LPT] & printer_dma_gate;
		irq_en[LDG_UART1] = dev_ok[LDG_UART1] & aux_output_two[0];
		dma_en[LDG_UART1] = dev_ok[LDG_UART1];
		irq_en[LDG_UART2] = dev_ok[LDG_UART2] & aux_output_two[1];
		dma_en[LDG_UART2] = dev_ok[LDG_UART2] & uart2_dma_enable;
		irq_en[LDG_IR] = dev_ok[LDG_IR];
		dma_en[LDG_IR] = dev_ok[LDG_IR];
	end

	// one gate per requesting device
	genvar gi;
	generate
		for (gi = 0; gi < NUM_GATED; gi++) begin : g_gate
			ldg_gate u_gate (
				.clock(clock),
				.rst(rst),
				.ce(ce),
				.irq_req(irq_req[gi]),
				.dma_req(dma_req[gi]),
				.irq_en(irq_en[gi]),
				.dma_en(dma_en[gi]),
				.irq_out_r(irq_out_r[gi]),
				.dma_out_r(dma_out_r[gi])
			);
		end
	endgenerate

endmodule : ldg_decode

// ==== bench/ldg_host.sv ====
// host master model issuing single i/o cycles
`timescale 1ns/1ps
module ldg_host
	import ldg_pkg::*;
(
	input wire logic clock,
	output logic [15:0] io_addr,
	output logic io_wr,
	output logic io_rd,
	output logic [7:0] io_wdata
);
	// idle bus at time zero
	initial begin
		io_addr = 16'hffff;
		io_wr = 1'b0;
		io_rd = 1'b0;
		io_wdata = 8'hff;
	end

	// one-cycle strobe launched and dropped on falling edges
	task automatic cycle(input ldg_addr_t a, input logic [7:0] d,
		input logic wr);
		@(negedge clock);
		io_addr = a;
		io_wdata = d;
		io_wr = wr;
		io_rd = ~wr;
		@(negedge clock);
		io_wr = 1'b0;
		io_rd = 1'b0;
		io_addr = ~a; // released bus shows no stale value
		io_wdata = ~d;
	endtask : cycle
endmodule : ldg_host

// ==== bench/ldg_decode_assertions.sv ====
// concurrent checks on the decoder ports
`timescale 1ns/1ps
module ldg_decode_assertions
	import ldg_pkg::*;
#(
	parameter int NUM_GATED = 5
)
(
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	input wire logic port_location_strap,
	input wire logic [15:0] io_addr,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [5:0] dev_active,
	input wire logic floppy_dma_irq_gate,
	input wire logic floppy_powerdown,
	input wire logic [1:0] aux_output_two,
	input wire logic uart2_dma_enable,
	input wire logic printer_irq_gate,
	input wire logic printer_dma_gate,
	input wire logic printer_ecr_active,
	input wire logic [2:0] printer_ecr_mode,
	input wire logic [4:0] irq_req,
	input wire logic [4:0] irq_out_r,
	input wire logic [4:0] dma_out_r,
	input wire logic [6:0] claim_r,
	input wire logic [15:0] claim_offset_r,
	input wire logic cfg_rvalid_r,
	input wire logic [15:0] cfg_port_r
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst || !ce);

	// decode and configuration port
	chk_claim_after_strobe: assert property (|claim_r |->
		$past(io_wr || io_rd)) else $error("claim without strobe");
	chk_claim_one_hot: assert property ($onehot0(claim_r))
		else $error("more than one claim");
	chk_port_legal_place: assert property (cfg_port_r inside
		{16'h002e, 16'h004e, [16'h0100:16'h07fe]} && !cfg_port_r[0])
		else $error("config port out of range");
	chk_port_strap_value: assert property ($past(rst) |->
		cfg_port_r == (port_location_strap ? 16'h004e : 16'h002e))
		else $error("config port reset place wrong");
	chk_index_port_claim: assert property (io_wr && io_addr == cfg_port_r
		|=> claim_r == 7'h40 && claim_offset_r == 16'h0000)
		else $error("index write not claimed");
	chk_data_read_valid: assert property (cfg_rvalid_r |->
		$past(io_rd) && claim_r[6]) else $error("stray read valid");

	// request gating
	chk_floppy_gate_open: assert property (
		(irq_out_r[0] || dma_out_r[0]) |->
		$past(floppy_dma_irq_gate && !floppy_powerdown && dev_active[0]))
		else $error("floppy request not gated");
	chk_uart_irq_gate: assert property (
		(irq_out_r[3:2] & ~$past(aux_output_two)) == 2'b00)
		else $error("uart irq not gated");
	chk_uart2_dma_gate: assert property (dma_out_r[3] |->
		$past(uart2_dma_enable)) else $error("uart2 dma not gated");
	chk_printer_dma_gate: assert property (dma_out_r[1] |->
		$past(printer_dma_gate)) else $error("printer dma not gated");
	chk_printer_irq_gate: assert property (irq_out_r[1] |->
		$past(printer_irq_gate || (printer_ecr_active
		&& printer_ecr_mode inside {3'b010, 3'b011, 3'b110})))
		else $error("printer irq not gated");

	cover property (cfg_rvalid_r);
	cover property (claim_r[1] && claim_offset_r == 16'h0402);
	cover property (irq_out_r[1] && !printer_irq_gate);
endmodule : ldg_decode_assertions

bind ldg_decode ldg_decode_assertions #(.NUM_GATED(NUM_GATED)) chk_inst (
	.clock, .rst, .ce, .port_location_strap, .io_addr, .io_wr, .io_rd,
	.dev_active, .floppy_dma_irq_gate, .floppy_powerdown, .aux_output_two,
	.uart2_dma_enable, .printer_irq_gate, .printer_dma_gate,
	.printer_ecr_active, .printer_ecr_mode, .irq_req, .irq_out_r, .dma_out_r,
	.claim_r, .claim_offset_r, .cfg_rvalid_r, .cfg_port_r);

// ==== bench/ldg_decode_test.sv ====
// self-checking bench for the logical device decoder
`timescale 1ns/1ps
module ldg_decode_test import ldg_pkg::*;;
	typedef struct packed {
		logic [15:0] a;
		logic [6:0] c;
		logic [15:0] o;
	} ldg_row_s;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic port_location_strap = 1'b0;
	logic [15:0] io_addr, claim_offset_r, cfg_port_r;
	logic io_wr, io_rd, cfg_rvalid_r;
	logic [7:0] io_wdata, cfg_rdata_r;
	logic [5:0] dev_active = 6'h3f;
	logic floppy_dma_irq_gate = 1'b1;
	logic floppy_powerdown = 1'b0;
	logic [1:0] aux_output_two = 2'b11;
	logic uart2_dma_enable = 1'b1;
	logic printer_irq_gate = 1'b1;
	logic printer_dma_gate = 1'b1;
	logic printer_ecr_active = 1'b0;
	logic [2:0] printer_ecr_mode = 3'b000;
	logic [4:0] irq_req = 5'h00;
	logic [4:0] dma_req = 5'h00;
	logic [4:0] irq_out_r, dma_out_r;
	logic [6:0] claim_r;
	int num_errors = 0;
	int n_compared = 0;
	int cycles = 0;
	// address, expected claim, expected offset
	ldg_row_s rows [18] = '{
		'{16'h0100, 7'h01, 16'h0}, '{16'h0105, 7'h01, 16'h5},
		'{16'h0106, 7'h00, 16'h0}, '{16'h0107, 7'h01, 16'h7},
		'{16'h013c, 7'h02, 16'h0}, '{16'h013e, 7'h02, 16'h2},
		'{16'h013f, 7'h00, 16'h0}, '{16'h053c, 7'h02, 16'h400},
		'{16'h053e, 7'h02, 16'h402}, '{16'h053d, 7'h00, 16'h0},
		'{16'h0140, 7'h04, 16'h0}, '{16'h0147, 7'h04, 16'h7},
		'{16'h0148, 7'h08, 16'h0}, '{16'h014f, 7'h08, 16'h7},
		'{16'h0180, 7'h10, 16'h0}, '{16'h0187, 7'h10, 16'h7},
		'{16'h020f, 7'h20, 16'hf}, '{16'h1100, 7'h00, 16'h0}};

	ldg_decode #(.NUM_GATED(5)) ldg_decode_inst (.clock, .rst, .ce,
		.port_location_strap, .io_addr, .io_wr, .io_rd, .io_wdata, .dev_active,
		.floppy_dma_irq_gate, .floppy_powerdown, .aux_output_two,
		.uart2_dma_enable, .printer_irq_gate, .printer_dma_gate,
		.printer_ecr_active, .printer_ecr_mode, .irq_req, .dma_req, .irq_out_r,
		.dma_out_r, .claim_r, .claim_offset_r, .cfg_rdata_r, .cfg_rvalid_r,
		.cfg_port_r);
	ldg_host ldg_host_inst (.clock, .io_addr, .io_wr, .io_rd, .io_wdata);

	// clock and cycle ceiling
	initial forever #5 clock = ~clock;
	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			tally_and_finish();
		end
	end

	task automatic check(input string what, input logic [15:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic tally_and_finish();
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : tally_and_finish

	// index then data through the current port
	task automatic cfg_wr(input logic [7:0] idx, dat);
		ldg_host_inst.cycle(cfg_port_r, idx, 1'b1);
		ldg_host_inst.cycle(cfg_port_r + 16'h0001, dat, 1'b1);
	endtask : cfg_wr

	task automatic probe(input logic [15:0] a, input logic [6:0] c,
		input logic [15:0] o);
		ldg_host_inst.cycle(a, 8'h00, 1'b0);
		check("claim", {9'h0, claim_r}, {9'h0, c});
		if (c != 7'h00) check("offset", claim_offset_r, o);
	endtask : probe

	task automatic gate(input logic [4:0] ei, ed);
		repeat (2) @(negedge clock);
		check("irq_out", {11'h0, irq_out_r}, {11'h0, ei});
		check("dma_out", {11'h0, dma_out_r}, {11'h0, ed});
	endtask : gate

	// main sequence
	initial begin
		repeat (10) @(negedge clock);
		rst = 1'b0;
		check("cfg_port", cfg_port_r, 16'h002e);
		cfg_wr(8'h20, 8'h40);
		cfg_wr(8'h23, 8'h4f);
		cfg_wr(8'h24, 8'h50);
		cfg_wr(8'h25, 8'h52);
		cfg_wr(8'h2b, 8'h30);
		cfg_wr(8'h30, 8'h20);
		for (int i = 0; i < 18; i++) begin
			probe(rows[i].a, rows[i].c, rows[i].o);
		end
		// eight-aligned printer base opens offsets three to seven
		cfg_wr(8'h23, 8'h4e);
		probe(16'h013b, 7'h02, 16'h0003);
		probe(16'h013f, 7'h02, 16'h0007);
		// relocate port byte by byte, low bit forced clear
		cfg_wr(8'h12, 8'h01);
		check("cfg_port", cfg_port_r, 16'h012e);
		cfg_wr(8'h13, 8'h61);
		check("cfg_port", cfg_port_r, 16'h0160);
		probe(16'h002e, 7'h00, 16'h0000);
		ldg_host_inst.cycle(16'h0160, 8'h20, 1'b1);
		ldg_host_inst.cycle(16'h0161, 8'h00, 1'b0);
		check("cfg_rdata", {8'h0, cfg_rdata_r}, 16'h0040);
		check("cfg_rvalid", {15'h0, cfg_rvalid_r}, 16'h0001);
		ldg_host_inst.cycle(16'h0160, 8'h00, 1'b0);
		check("cfg_index", {8'h0, cfg_rdata_r}, 16'h0020);
		// clock enable low: strobe neither claimed nor taken as index
		@(negedge clock);
		ce = 1'b0;
		ldg_host_inst.cycle(16'h0160, 8'h55, 1'b1);
		check("claim_frozen", {9'h0, claim_r}, 16'h0000);
		ce = 1'b1;
		ldg_host_inst.cycle(16'h0160, 8'h00, 1'b0);
		check("cfg_index", {8'h0, cfg_rdata_r}, 16'h0020);
		// unknown index reads back as zero
		ldg_host_inst.cycle(16'h0160, 8'h55, 1'b1);
		ldg_host_inst.cycle(16'h0161, 8'h00, 1'b0);
		check("cfg_unknown", {8'h0, cfg_rdata_r}, 16'h0000);
		// request gating
		irq_req = 5'h1f;
		dma_req = 5'h1f;
		gate(5'h1f, 5'h1f);
		floppy_dma_irq_gate = 1'b0;
		gate(5'h1e, 5'h1e);
		floppy_dma_irq_gate = 1'b1;
		floppy_powerdown = 1'b1;
		gate(5'h1e, 5'h1e);
		floppy_powerdown = 1'b0;
		aux_output_two = 2'b01;
		gate(5'h17, 5'h1f);
		aux_output_two = 2'b11;
		uart2_dma_enable = 1'b0;
		gate(5'h1f, 5'h17);
		uart2_dma_enable = 1'b1;
		printer_irq_gate = 1'b0;
		gate(5'h1d, 5'h1f);
		printer_ecr_active = 1'b1;
		for (int m = 0; m < 8; m++) begin
			printer_ecr_mode = m[2:0];
			printer_dma_gate = m[0];
			gate({3'b111, m == 2 || m == 3 || m == 6, 1'b1},
				{3'b111, m[0], 1'b1});
		end
		dev_active = 6'h3e;
		gate(5'h1c, {4'hf, 1'b0});
		probe(16'h0100, 7'h00, 16'h0000);
		cfg_wr(8'h2b, 8'h10);
		gate(5'h0c, 5'h0e);
		// second reset with the strap high
		rst = 1'b1;
		port_location_strap = 1'b1;
		repeat (2) @(negedge clock);
		rst = 1'b0;
		check("cfg_port", cfg_port_r, 16'h004e);
		tally_and_finish();
	end
endmodule : ldg_decode_test
